// >>> shared/dtc_consts.svh
// Constants for the dual timer/counter block.
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH
// Register offsets are word indices; the bus byte address is four times the index.
`define DTC_OFF_MODE 12'h089
`define DTC_OFF_CTRL 12'h088
`define DTC_OFF_T0L 12'h08a
`define DTC_OFF_T1L 12'h08b
`define DTC_OFF_T0H 12'h08c
`define DTC_OFF_T1H 12'h08d
`define DTC_OFF_STAT 12'h090
`define DTC_OFF_MASK 12'h094
`define DTC_OFF_OPT 12'h098
`define DTC_MODE_RESET 8'h00
`define DTC_MODE_MASK 8'h3f
`define DTC_T1_MODE_LSB 4
`define DTC_T0_GATE_BIT 3
`define DTC_T0_CSEL_BIT 2
`define DTC_T0_MODE_LSB 0
`define DTC_CTRL_T1RUN 6
`define DTC_CTRL_T0RUN 4
`define DTC_MCYCLE_CLKS 3'd6
`define DTC_LOW5_MAX 5'h1f
`endif

// >>> shared/dtc_pkg.sv
// Types shared by the dual timer/counter block.
package dtc_pkg;
    typedef enum logic [1:0] {
        DTC_MODE13,
        DTC_MODE16,
        DTC_MODE8R,
        DTC_MODESPLIT
    } dtc_mode_t;
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } dtc_count_t;
    typedef struct packed {
        logic count;
        logic reload;
    } dtc_step_t;
endpackage : dtc_pkg

// >>> core/dtc_counter.sv
// One timer/counter datapath: 13, 16, 8-reload and split modes with byte writes.
`timescale 1ns/1ps
`include "dtc_consts.svh"
module dtc_counter
    import dtc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire dtc_mode_t mode,
    input wire logic inc_low,
    input wire logic inc_high,
    input wire logic wr_low,
    input wire logic wr_high,
    input wire logic [7:0] wdata,
    output dtc_count_t count,
    output logic ovf_low,
    output logic ovf_high
);
    dtc_count_t next_count;

    always_comb begin
        next_count = count;
        ovf_low = 1'b0;
        ovf_high = 1'b0;
        case (mode)
            DTC_MODE13: begin
                if (inc_low) begin
                    // Low five bits prescale the high byte.
                    if (count.low[4:0] == `DTC_LOW5_MAX) begin
                        next_count.low = {count.low[7:5], 5'h00};
                        next_count.high = count.high + 8'h01;
                        ovf_low = (count.high == 8'hff);
                    end else begin
                        next_count.low = count.low + 8'h01;
                    end
                end
            end
            DTC_MODE16: begin
                if (inc_low) begin
                    next_count = count + 16'h0001;
                    ovf_low = (count == 16'hffff);
                end
            end
            DTC_MODE8R: begin
                if (inc_low) begin
                    if (count.low == 8'hff) begin
                        next_count.low = count.high;
                        ovf_low = 1'b1;
                    end else begin
                        next_count.low = count.low + 8'h01;
                    end
                end
            end
            DTC_MODESPLIT: begin
                if (inc_low) begin
                    next_count.low = count.low + 8'h01;
                    ovf_low = (count.low == 8'hff);
                end
                if (inc_high) begin
                    next_count.high = count.high + 8'h01;
                    ovf_high = (count.high == 8'hff);
                end
            end
            default: begin
                next_count = count;
            end
        endcase
        if (wr_low) begin
            next_count.low = wdata;
        end
        if (wr_high) begin
            next_count.high = wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end
endmodule : dtc_counter

// >>> core/dtc_timer.sv
// Dual timer/counter with APB registers, edge counting, gating and overflow toggle.
//
// Behaviour
// - Timer function counts once per machine cycle of six clocks.
// - Counter function samples count pin each machine cycle, counts high-then-low.
// - New count appears in the machine cycle after the detected transition.
// - An edge takes two machine cycles to recognise; rate at most clock/12.
// - Mode bit 2 selects internal cycles or external count pin for timer 0.
// - Gate set: timer 0 counts only with interrupt pin high and run set.
// - Gate clear: timer 0 counts whenever its run bit is set.
// - Two-bit mode fields at bits 5:4 (timer 1) and 1:0 (timer 0).
// - Modes 0-2 match for both timers; mode 3 differs.
// - Optional toggle of timer 0 count pin on each timer 0 overflow.
// - Mode 0 is a 13-bit counter, flag on rollover to zero.
// - Mode 1 is a full 16-bit counter.
// - Mode 2 low byte counts, reloads from high byte on overflow, sets flag.
// - Timer 1 mode 3 stops; timer 0 mode 3 splits, high byte uses timer 1 controls.
`timescale 1ns/1ps
`include "dtc_consts.svh"
module dtc_timer
    import dtc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_pin_zero_in,
    output logic count_pin_zero_out,
    output logic count_pin_zero_oe,
    input wire logic external_interrupt_zero_pin,
    output logic irq
);
    logic [7:0] timer_mode_control;
    logic timer_zero_run_bit;
    logic timer_one_run_bit;
    logic [1:0] status;
    logic [1:0] irq_mask;
    logic toggle_enable;
    logic [2:0] phase;
    logic pin_sample;
    logic edge_seen;
    logic [7:0] next_timer_mode_control;
    logic next_timer_zero_run_bit;
    logic next_timer_one_run_bit;
    logic [1:0] next_status;
    logic [1:0] next_irq_mask;
    logic next_toggle_enable;
    logic [2:0] next_phase;
    logic next_pin_sample;
    logic next_edge_seen;
    logic next_pin_out;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_irq;
    logic mcycle;
    logic t0_gate;
    logic t0_csel;
    dtc_mode_t t0_mode;
    dtc_mode_t t1_mode;
    logic t0_enable;
    logic t0_inc;
    logic t0h_inc;
    logic t1_inc;
    logic wr_access;
    logic rd_access;
    dtc_count_t t0_count;
    dtc_count_t t1_count;
    logic t0_ovf_low;
    logic t0_ovf_high;
    logic t1_ovf_low;
    logic t1_ovf_unused;
    logic t0_overflow;
    logic t1_overflow;

    function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
        hit = (addr == {off[9:0], 2'b00});
    endfunction : hit

    assign wr_access = psel && penable && pwrite && !pready;
    assign rd_access = psel && penable && !pwrite && !pready;
    assign mcycle = (phase == `DTC_MCYCLE_CLKS - 3'd1);
    assign t0_gate = timer_mode_control[`DTC_T0_GATE_BIT];
    assign t0_csel = timer_mode_control[`DTC_T0_CSEL_BIT];
    assign t0_mode = dtc_mode_t'(timer_mode_control[`DTC_T0_MODE_LSB +: 2]);
    assign t1_mode = dtc_mode_t'(timer_mode_control[`DTC_T1_MODE_LSB +: 2]);
    // Gate high makes the interrupt pin a second enable condition.
    assign t0_enable = timer_zero_run_bit && (!t0_gate || external_interrupt_zero_pin);
    // Edge detected in one machine cycle is counted at the next boundary.
    assign t0_inc = t0_enable && mcycle && (t0_csel ? edge_seen : 1'b1);
    // In split mode the high byte is a cycle timer owned by timer 1's run bit.
    assign t0h_inc = (t0_mode == DTC_MODESPLIT) && timer_one_run_bit && mcycle;
    assign t1_inc = timer_one_run_bit && mcycle && (t1_mode != DTC_MODESPLIT) && !t0h_inc;
    assign t0_overflow = t0_ovf_low;
    assign t1_overflow = t1_ovf_low || t0_ovf_high;

    dtc_counter u_t0 (
        .pclk(pclk),
        .presetn(presetn),
        .mode(t0_mode),
        .inc_low(t0_inc),
        .inc_high(t0h_inc),
        .wr_low(wr_access && hit(paddr, `DTC_OFF_T0L)),
        .wr_high(wr_access && hit(paddr, `DTC_OFF_T0H)),
        .wdata(pwdata[7:0]),
        .count(t0_count),
        .ovf_low(t0_ovf_low),
        .ovf_high(t0_ovf_high)
    );

    dtc_counter u_t1 (
        .pclk(pclk),
        .presetn(presetn),
        .mode(t1_mode),
        .inc_low(t1_inc),
        .inc_high(1'b0),
        .wr_low(wr_access && hit(paddr, `DTC_OFF_T1L)),
        .wr_high(wr_access && hit(paddr, `DTC_OFF_T1H)),
        .wdata(pwdata[7:0]),
        .count(t1_count),
        .ovf_low(t1_ovf_low),
        .ovf_high(t1_ovf_unused)
    );

    always_comb begin
        next_phase = mcycle ? 3'd0 : phase + 3'd1;
        next_pin_sample = pin_sample;
        next_edge_seen = edge_seen;
        if (mcycle) begin
            // One sample per machine cycle; high then low marks an edge.
            next_pin_sample = count_pin_zero_in;
            next_edge_seen = pin_sample && !count_pin_zero_in;
        end
    end

    always_comb begin
        next_timer_mode_control = timer_mode_control;
        next_timer_zero_run_bit = timer_zero_run_bit;
        next_timer_one_run_bit = timer_one_run_bit;
        next_irq_mask = irq_mask;
        next_toggle_enable = toggle_enable;
        next_status = status;
        next_pin_out = count_pin_zero_out;
        next_pready = psel && penable && !pready;
        next_pslverr = 1'b0;
        next_prdata = 32'h0000_0000;
        if (wr_access) begin
            if (hit(paddr, `DTC_OFF_MODE)) begin
                next_timer_mode_control = pwdata[7:0] & `DTC_MODE_MASK;
            end else if (hit(paddr, `DTC_OFF_CTRL)) begin
                next_timer_one_run_bit = pwdata[`DTC_CTRL_T1RUN];
                next_timer_zero_run_bit = pwdata[`DTC_CTRL_T0RUN];
            end else if (hit(paddr, `DTC_OFF_STAT)) begin
                next_status = status & ~pwdata[1:0];
            end else if (hit(paddr, `DTC_OFF_MASK)) begin
                next_irq_mask = pwdata[1:0];
            end else if (hit(paddr, `DTC_OFF_OPT)) begin
                next_toggle_enable = pwdata[0];
                if (pwdata[0] && !toggle_enable) begin
                    next_pin_out = 1'b1;
                end
            end else if (!hit(paddr, `DTC_OFF_T0L) && !hit(paddr, `DTC_OFF_T0H)
                         && !hit(paddr, `DTC_OFF_T1L) && !hit(paddr, `DTC_OFF_T1H)) begin
                next_pslverr = 1'b1;
            end
        end
        if (rd_access) begin
            if (hit(paddr, `DTC_OFF_MODE)) begin
                next_prdata = {24'h000000, timer_mode_control};
            end else if (hit(paddr, `DTC_OFF_CTRL)) begin
                next_prdata = {24'h000000, status[1], timer_one_run_bit, status[0],
                               timer_zero_run_bit, 4'h0};
            end else if (hit(paddr, `DTC_OFF_T0L)) begin
                next_prdata = {24'h000000, t0_count.low};
            end else if (hit(paddr, `DTC_OFF_T0H)) begin
                next_prdata = {24'h000000, t0_count.high};
            end else if (hit(paddr, `DTC_OFF_T1L)) begin
                next_prdata = {24'h000000, t1_count.low};
            end else if (hit(paddr, `DTC_OFF_T1H)) begin
                next_prdata = {24'h000000, t1_count.high};
            end else if (hit(paddr, `DTC_OFF_STAT)) begin
                next_prdata = {30'h00000000, status};
            end else if (hit(paddr, `DTC_OFF_MASK)) begin
                next_prdata = {30'h00000000, irq_mask};
            end else if (hit(paddr, `DTC_OFF_OPT)) begin
                next_prdata = {31'h00000000, toggle_enable};
            end else begin
                next_pslverr = 1'b1;
            end
        end
        // Hardware set wins over a software clear in the same cycle.
        if (t0_overflow) begin
            next_status[0] = 1'b1;
        end
        if (t1_overflow) begin
            next_status[1] = 1'b1;
        end
        if (toggle_enable && t0_overflow) begin
            next_pin_out = !count_pin_zero_out;
        end
        next_irq = |(next_status & next_irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 3'd0;
            pin_sample <= 1'b0;
            edge_seen <= 1'b0;
            timer_mode_control <= `DTC_MODE_RESET;
            timer_zero_run_bit <= 1'b0;
            timer_one_run_bit <= 1'b0;
            status <= 2'b00;
            irq_mask <= 2'b00;
            toggle_enable <= 1'b0;
            count_pin_zero_out <= 1'b1;
            count_pin_zero_oe <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end else begin
            phase <= next_phase;
            pin_sample <= next_pin_sample;
            edge_seen <= next_edge_seen;
            timer_mode_control <= next_timer_mode_control;
            timer_zero_run_bit <= next_timer_zero_run_bit;
            timer_one_run_bit <= next_timer_one_run_bit;
            status <= next_status;
            irq_mask <= next_irq_mask;
            toggle_enable <= next_toggle_enable;
            count_pin_zero_out <= next_pin_out;
            count_pin_zero_oe <= next_toggle_enable;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            irq <= next_irq;
        end
    end
endmodule : dtc_timer

// >>> test/dtc_timer_asserts.sv
// Port checker for the dual timer/counter.
`timescale 1ns/1ps
module dtc_timer_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic count_pin_zero_in,
    input wire logic count_pin_zero_out,
    input wire logic count_pin_zero_oe,
    input wire logic external_interrupt_zero_pin,
    input wire logic irq
);
    logic bad;
    logic next_bad;
    always_comb begin
        next_bad = bad;
        if (psel && !penable) begin
            next_bad = !(paddr inside {12'h220, 12'h224, 12'h228, 12'h22c, 12'h230,
                                       12'h234, 12'h240, 12'h250, 12'h260});
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bad <= 1'h0;
        end else begin
            bad <= next_bad;
        end
    end
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_ready_answer: assert property (psel && penable && !pready |=> pready)
        else $error("no ready after access");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_no_stray: assert property (!(psel && penable) |=> !pready)
        else $error("ready without access");
    chk_err_addr: assert property (pready |-> pslverr == bad)
        else $error("slave error on wrong address");
    chk_err_data: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("data on refused access");
    chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_pin_reset: assert property ($rose(presetn)
        |-> count_pin_zero_out && !count_pin_zero_oe) else $error("pin not idle after reset");
    chk_toggle_gap: assert property (count_pin_zero_oe && $past(count_pin_zero_oe)
        && $changed(count_pin_zero_out) |=> $stable(count_pin_zero_out) [*5])
        else $error("toggles closer than a machine cycle");
    cover property (pready && pslverr);
    cover property ($rose(irq));
    cover property ($changed(count_pin_zero_out));
endmodule : dtc_timer_asserts
bind dtc_timer dtc_timer_asserts u_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_pin_zero_in(count_pin_zero_in),
    .count_pin_zero_out(count_pin_zero_out), .count_pin_zero_oe(count_pin_zero_oe),
    .external_interrupt_zero_pin(external_interrupt_zero_pin), .irq(irq));

// >>> test/dtc_pin_model.sv
// Far-side model driving the count pin and the gate pin.
`timescale 1ns/1ps
module dtc_pin_model (
    input wire logic pclk,
    input wire logic start,
    input wire logic [3:0] n_edges,
    input wire logic gate_level,
    output logic count_pin,
    output logic gate_pin,
    output logic busy
);
    assign gate_pin = gate_level;
    initial begin
        count_pin = 1'h1;
        busy = 1'h0;
        forever begin
            @(posedge pclk);
            if (start) begin
                busy <= 1'h1;
                for (int i = 0; i < n_edges; i++) begin
                    repeat (12) @(posedge pclk);
                    count_pin <= 1'h0;
                    repeat (12) @(posedge pclk);
                    count_pin <= 1'h1;
                end
                busy <= 1'h0;
            end
        end
    end
endmodule : dtc_pin_model

// >>> test/dual_timer_counter_bench.sv
// Self-checking bench for the dual timer/counter.
`timescale 1ns/1ps
module dual_timer_counter_bench;
    localparam logic [28:0] REGS [4] = '{{12'h224, 8'hff, 8'h3f, 1'h0},
        {12'h228, 8'ha5, 8'ha5, 1'h0}, {12'h250, 8'h03, 8'h03, 1'h0},
        {12'h280, 8'hff, 8'h00, 1'h1}};
    localparam logic [27:0] TMRS [8] = '{{1'h0, 2'h0, 8'h1f, 8'h00, 8'h01, 1'h0},
        {1'h0, 2'h0, 8'h1f, 8'hff, 8'h00, 1'h1}, {1'h0, 2'h1, 8'h1f, 8'h00, 8'h00, 1'h0},
        {1'h0, 2'h1, 8'hfe, 8'hff, 8'h00, 1'h1}, {1'h0, 2'h2, 8'hfe, 8'h77, 8'h77, 1'h1},
        {1'h1, 2'h2, 8'hfe, 8'h77, 8'h77, 1'h1}, {1'h1, 2'h3, 8'hfe, 8'hff, 8'hff, 1'h0},
        {1'h0, 2'h3, 8'hfe, 8'h40, 8'h40, 1'h1}};
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rdata;
    logic pready, pslverr, pin_out, pin_oe, irq, gate_pin, model_pin, busy, err;
    logic start = 1'h0;
    logic gate_level = 1'h0;
    logic [3:0] n_edges = 4'h0;
    int failures = 0;
    int n_compared = 0;
    int gap;
    wire logic pin_wire = pin_oe ? pin_out : model_pin;
    always #2.5 pclk = ~pclk;
    dtc_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .count_pin_zero_in(pin_wire), .count_pin_zero_out(pin_out),
        .count_pin_zero_oe(pin_oe), .external_interrupt_zero_pin(gate_pin), .irq(irq));
    dtc_pin_model u_pins (.pclk(pclk), .start(start), .n_edges(n_edges),
        .gate_level(gate_level), .count_pin(model_pin), .gate_pin(gate_pin), .busy(busy));
    task automatic wrap_up;
        $display("Compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    task automatic lost;
        failures++;
        wrap_up();
    endtask : lost
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20) lost();
        rdata = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask : apb
    task automatic wait_toggle(output int n);
        logic last;
        last = pin_out;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pin_out === last && n < 100);
        if (n >= 100) lost();
    endtask : wait_toggle
    task automatic count_case(input logic [31:0] m, input logic g, input logic [3:0] k,
        input logic [7:0] e);
        int n;
        gate_level <= g;
        apb(1'h1, 12'h224, m);
        apb(1'h1, 12'h228, 32'h0);
        apb(1'h1, 12'h220, 32'h10);
        n_edges <= k;
        start <= 1'h1;
        @(posedge pclk);
        start <= 1'h0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((busy !== 1'h0 || n < 2) && n < 400);
        if (n >= 400) lost();
        repeat (12) @(posedge pclk);
        apb(1'h1, 12'h220, 32'h0);
        apb(1'h0, 12'h228, 32'h0);
        check("edge count", rdata, {24'h0, e});
    endtask : count_case
    task automatic run_row(input logic [27:0] r);
        apb(1'h1, 12'h224, r[27] ? {26'h0, r[26:25], 4'h0} : {30'h0, r[26:25]});
        apb(1'h1, 12'h228 + {9'h0, r[27], 2'h0}, {24'h0, r[24:17]});
        apb(1'h1, 12'h230 + {9'h0, r[27], 2'h0}, {24'h0, r[16:9]});
        apb(1'h1, 12'h240, 32'h3);
        apb(1'h1, 12'h220, r[27] ? 32'h40 : 32'h10);
        repeat (24) @(posedge pclk);
        apb(1'h1, 12'h220, 32'h0);
        apb(1'h0, 12'h230 + {9'h0, r[27], 2'h0}, 32'h0);
        check("high byte", rdata, {24'h0, r[8:1]});
        apb(1'h0, 12'h240, 32'h0);
        check("overflow flag", {31'h0, rdata[r[27]]}, {31'h0, r[0]});
    endtask : run_row
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        check("pin idle", {30'h0, pin_oe, pin_out}, 32'h1);
        apb(1'h0, 12'h224, 32'h0);
        check("mode reset", rdata, 32'h0);
        foreach (REGS[i]) begin
            apb(1'h1, REGS[i][28:17], {24'h0, REGS[i][16:9]});
            check("slave error", {31'h0, err}, {31'h0, REGS[i][0]});
            apb(1'h0, REGS[i][28:17], 32'h0);
            check("readback", rdata, {24'h0, REGS[i][8:1]});
        end
        apb(1'h1, 12'h250, 32'h1);
        foreach (TMRS[i]) run_row(TMRS[i]);
        apb(1'h1, 12'h224, 32'h2);
        apb(1'h1, 12'h228, 32'hfb);
        apb(1'h1, 12'h230, 32'hfb);
        apb(1'h1, 12'h240, 32'h3);
        apb(1'h1, 12'h260, 32'h1);
        check("toggle start", {30'h0, pin_oe, pin_out}, 32'h3);
        apb(1'h1, 12'h220, 32'h10);
        wait_toggle(gap);
        wait_toggle(gap);
        check("toggle gap", gap, 32'h1e);
        repeat (2) @(posedge pclk);
        check("irq on", {31'h0, irq}, 32'h1);
        apb(1'h1, 12'h250, 32'h0);
        check("irq masked", {31'h0, irq}, 32'h0);
        apb(1'h1, 12'h220, 32'h0);
        apb(1'h1, 12'h260, 32'h0);
        apb(1'h1, 12'h240, 32'h3);
        apb(1'h0, 12'h240, 32'h0);
        check("status cleared", rdata, 32'h0);
        count_case(32'h5, 1'h0, 4'h5, 8'h05);
        count_case(32'hd, 1'h0, 4'h3, 8'h00);
        count_case(32'hd, 1'h1, 4'h3, 8'h03);
        wrap_up();
    end
endmodule : dual_timer_counter_bench
